// ===== hdl/lcdc_consts.vh
`ifndef LCDC_CONSTS_VH
`define LCDC_CONSTS_VH

// Register indices; byte address is four times the index
`define LCDC_IDX_PWR_DUTY    16'hFF60
`define LCDC_IDX_FORCE_PAGE  16'hFF61
`define LCDC_IDX_CONTRAST    16'hFF62
`define LCDC_IDX_STATUS      16'hFF63
`define LCDC_IDX_LSB         2

// Power and duty register fields
`define LCDC_BIT_POWER       0
`define LCDC_BIT_SPARE       1
`define LCDC_BIT_DUTY_LO     2
`define LCDC_BIT_DUTY_HI     3

// Force and page register fields
`define LCDC_BIT_PAGE        0
`define LCDC_BIT_ALL_ON      1
`define LCDC_BIT_ALL_OFF     2
`define LCDC_BIT_EXP_EN      3

// Status register fields
`define LCDC_BIT_SETTLED     0

// Reset values
`define LCDC_RST_PWR_DUTY    4'h0
`define LCDC_RST_FORCE_PAGE  4'h4
`define LCDC_RST_CONTRAST    4'h0

// Duty codes and common line counts
`define LCDC_DUTY_17         2'h0
`define LCDC_DUTY_16         2'h1
`define LCDC_COMS_8          5'h08
`define LCDC_COMS_16         5'h10
`define LCDC_COMS_17         5'h11

// Display memory page bases
`define LCDC_PAGE0_BASE      16'hF000
`define LCDC_PAGE1_BASE      16'hF100

// Bus responses
`define LCDC_RESP_OKAY       2'h0
`define LCDC_RESP_SLVERR     2'h2
`define LCDC_ZERO_PAD        28'h0000000

// Drive settle time
`define LCDC_SETTLE_MS       100
`define LCDC_CLK_KHZ         50000

`endif

// ===== hdl/lcdc_ctrl_regs.v
// Summary of operation
// - Power bit enables generator; clear grounds voltages
// - Duty field selects 1/8, 1/16, 1/17
// - Force-on drives every segment ON
// - Force-off drives every segment OFF
// - Both force bits set means all on
// - Page bit picks upper or lower page
// - Page bit only storage at 1/16, 1/17
// - Contrast code sets sixteen drive levels
// - Contrast resets to CONTRAST_INIT, zero by default
// - Reset clears controls, sets force-off
// - Expansion driver signal enable, resets off
// - Memory bit one lights the dot
`timescale 1ns/1ps
`include "lcdc_consts.vh"

module lcdc_ctrl_regs #(
	parameter                    ADDR_W        = 18,
	parameter                    SEG_N         = 60,
	parameter                    SETTLE_CYCLES =
		`LCDC_SETTLE_MS * `LCDC_CLK_KHZ,
	parameter [3:0]              CONTRAST_INIT = `LCDC_RST_CONTRAST
) (
	input  wire                  sys_clk,
	input  wire                  srst,
	input  wire [ADDR_W-1:0]     s_axi_awaddr,
	input  wire [2:0]            s_axi_awprot,
	input  wire                  s_axi_awvalid,
	output wire                  s_axi_awready,
	input  wire [31:0]           s_axi_wdata,
	input  wire [3:0]            s_axi_wstrb,
	input  wire                  s_axi_wvalid,
	output wire                  s_axi_wready,
	output wire [1:0]            s_axi_bresp,
	output wire                  s_axi_bvalid,
	input  wire                  s_axi_bready,
	input  wire [ADDR_W-1:0]     s_axi_araddr,
	input  wire [2:0]            s_axi_arprot,
	input  wire                  s_axi_arvalid,
	output wire                  s_axi_arready,
	output wire [31:0]           s_axi_rdata,
	output wire [1:0]            s_axi_rresp,
	output wire                  s_axi_rvalid,
	input  wire                  s_axi_rready,
	input  wire [SEG_N-1:0]      dot_mem_bits,
	output wire                  bias_generator_power,
	output wire                  drive_to_ground,
	output wire                  duty_select_low,
	output wire                  duty_select_high,
	output wire [4:0]            common_terminals_used,
	output wire                  force_all_dots_on,
	output wire                  force_all_dots_off,
	output wire [SEG_N-1:0]      segment_terminals_on,
	output wire                  display_page_select,
	output wire [15:0]           display_page_base,
	output wire [3:0]            contrast_code,
	output wire                  expansion_driver_signal_enable,
	output wire                  drive_settled
);

	localparam                   CNT_W = 32;
	localparam [CNT_W-1:0]       SETTLE_LAST = SETTLE_CYCLES - 1;

	// Bus handshake state
	reg                          awready_reg;
	reg                          wready_reg;
	reg                          bvalid_reg;
	reg  [1:0]                   bresp_reg;
	reg                          arready_reg;
	reg                          rvalid_reg;
	reg  [1:0]                   rresp_reg;
	reg  [31:0]                  rdata_reg;
	reg  [15:0]                  wr_idx_reg;
	reg  [3:0]                   wr_data_reg;
	reg                          wr_lane_reg;

	// Control storage
	reg  [3:0]                   pwr_duty_reg;
	reg  [3:0]                   force_page_reg;
	reg  [3:0]                   contrast_reg;

	// Derived outputs
	reg                          power_out_reg;
	reg                          ground_out_reg;
	reg  [4:0]                   coms_reg;
	reg  [4:0]                   coms_next;
	reg                          on_out_reg;
	reg                          off_out_reg;
	reg  [SEG_N-1:0]             seg_reg;
	reg  [SEG_N-1:0]             seg_next;
	reg  [15:0]                  base_reg;
	reg  [15:0]                  base_next;
	reg  [CNT_W-1:0]             settle_cnt_reg;
	reg                          settled_reg;

	wire                         eighth_duty;
	wire                         wr_go;
	wire [15:0]                  ar_idx;
	wire [15:0]                  aw_idx;

	assign eighth_duty = pwr_duty_reg[`LCDC_BIT_DUTY_HI];
	assign wr_go       = ~awready_reg & ~wready_reg & ~bvalid_reg;
	assign aw_idx      = s_axi_awaddr[ADDR_W-1:`LCDC_IDX_LSB];
	assign ar_idx      = s_axi_araddr[ADDR_W-1:`LCDC_IDX_LSB];

	// Write channel: address and data taken in either order
	always @(posedge sys_clk) begin
		if (srst) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `LCDC_RESP_OKAY;
			wr_idx_reg  <= 16'h0000;
			wr_data_reg <= 4'h0;
			wr_lane_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				awready_reg <= 1'b0;
				wr_idx_reg  <= aw_idx;
			end
			if (s_axi_wvalid && wready_reg) begin
				wready_reg  <= 1'b0;
				wr_data_reg <= s_axi_wdata[3:0];
				wr_lane_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				if (wr_idx_reg == `LCDC_IDX_PWR_DUTY ||
				    wr_idx_reg == `LCDC_IDX_FORCE_PAGE ||
				    wr_idx_reg == `LCDC_IDX_CONTRAST ||
				    wr_idx_reg == `LCDC_IDX_STATUS) begin
					bresp_reg <= `LCDC_RESP_OKAY;
				end else begin
					bresp_reg <= `LCDC_RESP_SLVERR;
				end
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Register storage
	always @(posedge sys_clk) begin
		if (srst) begin
			pwr_duty_reg   <= `LCDC_RST_PWR_DUTY;
			force_page_reg <= `LCDC_RST_FORCE_PAGE;
			contrast_reg   <= CONTRAST_INIT;
		end else if (wr_go && wr_lane_reg) begin
			case (wr_idx_reg)
			`LCDC_IDX_PWR_DUTY: begin
				pwr_duty_reg <= wr_data_reg;
			end
			`LCDC_IDX_FORCE_PAGE: begin
				force_page_reg <= wr_data_reg;
			end
			`LCDC_IDX_CONTRAST: begin
				contrast_reg <= wr_data_reg;
			end
			default: begin
			end
			endcase
		end
	end

	// Read channel
	always @(posedge sys_clk) begin
		if (srst) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `LCDC_RESP_OKAY;
			rdata_reg   <= 32'h00000000;
		end else begin
			if (s_axi_arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rresp_reg   <= `LCDC_RESP_OKAY;
				case (ar_idx)
				`LCDC_IDX_PWR_DUTY: begin
					rdata_reg <= {`LCDC_ZERO_PAD, pwr_duty_reg};
				end
				`LCDC_IDX_FORCE_PAGE: begin
					rdata_reg <= {`LCDC_ZERO_PAD, force_page_reg};
				end
				`LCDC_IDX_CONTRAST: begin
					rdata_reg <= {`LCDC_ZERO_PAD, contrast_reg};
				end
				`LCDC_IDX_STATUS: begin
					rdata_reg <= {31'h00000000, settled_reg};
				end
				default: begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= `LCDC_RESP_SLVERR;
				end
				endcase
			end
			if (rvalid_reg && s_axi_rready) begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// Duty decode to common line count
	always @* begin
		if (eighth_duty) begin
			coms_next = `LCDC_COMS_8;
		end else if (pwr_duty_reg[`LCDC_BIT_DUTY_LO]) begin
			coms_next = `LCDC_COMS_16;
		end else begin
			coms_next = `LCDC_COMS_17;
		end
	end

	// Page base, meaningful only at 1/8 duty
	always @* begin
		if (eighth_duty && force_page_reg[`LCDC_BIT_PAGE]) begin
			base_next = `LCDC_PAGE1_BASE;
		end else begin
			base_next = `LCDC_PAGE0_BASE;
		end
	end

	// Segment data with force priority
	always @* begin
		if (force_page_reg[`LCDC_BIT_ALL_ON]) begin
			seg_next = {SEG_N{1'b1}};
		end else if (force_page_reg[`LCDC_BIT_ALL_OFF]) begin
			seg_next = {SEG_N{1'b0}};
		end else begin
			seg_next = dot_mem_bits;
		end
	end

	// Output registers
	always @(posedge sys_clk) begin
		if (srst) begin
			power_out_reg  <= 1'b0;
			ground_out_reg <= 1'b1;
			coms_reg       <= `LCDC_COMS_17;
			on_out_reg     <= 1'b0;
			off_out_reg    <= 1'b1;
			seg_reg        <= {SEG_N{1'b0}};
			base_reg       <= `LCDC_PAGE0_BASE;
		end else begin
			power_out_reg  <= pwr_duty_reg[`LCDC_BIT_POWER];
			ground_out_reg <= ~pwr_duty_reg[`LCDC_BIT_POWER];
			coms_reg       <= coms_next;
			on_out_reg     <= force_page_reg[`LCDC_BIT_ALL_ON];
			off_out_reg    <= force_page_reg[`LCDC_BIT_ALL_OFF] &
				~force_page_reg[`LCDC_BIT_ALL_ON];
			seg_reg        <= seg_next;
			base_reg       <= base_next;
		end
	end

	// Drive voltage settle timer after power on
	always @(posedge sys_clk) begin
		if (srst) begin
			settle_cnt_reg <= {CNT_W{1'b0}};
			settled_reg    <= 1'b0;
		end else if (!pwr_duty_reg[`LCDC_BIT_POWER]) begin
			settle_cnt_reg <= {CNT_W{1'b0}};
			settled_reg    <= 1'b0;
		end else if (!settled_reg) begin
			if (settle_cnt_reg == SETTLE_LAST) begin
				settled_reg <= 1'b1;
			end else begin
				settle_cnt_reg <= settle_cnt_reg + 1'b1;
			end
		end
	end

	assign s_axi_awready       = awready_reg;
	assign s_axi_wready        = wready_reg;
	assign s_axi_bvalid        = bvalid_reg;
	assign s_axi_bresp         = bresp_reg;
	assign s_axi_arready       = arready_reg;
	assign s_axi_rvalid        = rvalid_reg;
	assign s_axi_rresp         = rresp_reg;
	assign s_axi_rdata         = rdata_reg;
	assign bias_generator_power = power_out_reg;
	assign drive_to_ground     = ground_out_reg;
	assign duty_select_low     = pwr_duty_reg[`LCDC_BIT_DUTY_LO];
	assign duty_select_high    = pwr_duty_reg[`LCDC_BIT_DUTY_HI];
	assign common_terminals_used = coms_reg;
	assign force_all_dots_on   = on_out_reg;
	assign force_all_dots_off  = off_out_reg;
	assign segment_terminals_on = seg_reg;
	assign display_page_select = force_page_reg[`LCDC_BIT_PAGE];
	assign display_page_base   = base_reg;
	assign contrast_code       = contrast_reg;
	assign expansion_driver_signal_enable =
		force_page_reg[`LCDC_BIT_EXP_EN];
	assign drive_settled       = settled_reg;

endmodule // lcdc_ctrl_regs

// ===== bench/lcdc_ctrl_properties.sv
`timescale 1ns/1ps
module lcdc_ctrl_checker #(
	parameter SEG_N = 60
) (
	input logic             sys_clk,
	input logic             srst,
	input logic             s_axi_bvalid,
	input logic             s_axi_bready,
	input logic             s_axi_rvalid,
	input logic             s_axi_rready,
	input logic [SEG_N-1:0] dot_mem_bits,
	input logic             bias_generator_power,
	input logic             drive_to_ground,
	input logic             duty_select_low,
	input logic             duty_select_high,
	input logic [4:0]       common_terminals_used,
	input logic             force_all_dots_on,
	input logic             force_all_dots_off,
	input logic [SEG_N-1:0] segment_terminals_on,
	input logic             display_page_select,
	input logic [15:0]      display_page_base,
	input logic             drive_settled
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	pwr_ground_a: assert property (
		bias_generator_power ^ drive_to_ground) else $error("ground");
	pwr_off_a: assert property ($fell(bias_generator_power)
		|-> ##[0:1] !drive_settled) else $error("settled");
	duty_coms_a: assert property (common_terminals_used ==
		($past(duty_select_high) ? 5'h08 : $past(duty_select_low) ?
		5'h10 : 5'h11)) else $error("coms");
	all_on_a: assert property (force_all_dots_on
		|-> &segment_terminals_on && !force_all_dots_off)
		else $error("all on");
	all_off_a: assert property (force_all_dots_off
		|-> segment_terminals_on == '0) else $error("all off");
	page_base_a: assert property (display_page_base ==
		(($past(duty_select_high) && $past(display_page_select)) ?
		16'hF100 : 16'hF000)) else $error("base");
	normal_dots_a: assert property (!force_all_dots_on &&
		!force_all_dots_off |-> segment_terminals_on ==
		$past(dot_mem_bits)) else $error("dots");
	reset_state_a: assert property ($past(srst) |->
		force_all_dots_off && !bias_generator_power) else $error("rst");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("bresp held");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("rresp held");
	unpowered_settle_a: assert property (!bias_generator_power
		|-> !drive_settled) else $error("settled unpowered");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (common_terminals_used == 5'h08);
	cover property (drive_settled);
	cover property (force_all_dots_on);
endmodule // lcdc_ctrl_checker
bind lcdc_ctrl_regs lcdc_ctrl_checker #(
	.SEG_N(SEG_N)
) i_chk (
	.sys_clk(sys_clk),
	.srst(srst),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.dot_mem_bits(dot_mem_bits),
	.bias_generator_power(bias_generator_power),
	.drive_to_ground(drive_to_ground),
	.duty_select_low(duty_select_low),
	.duty_select_high(duty_select_high),
	.common_terminals_used(common_terminals_used),
	.force_all_dots_on(force_all_dots_on),
	.force_all_dots_off(force_all_dots_off),
	.segment_terminals_on(segment_terminals_on),
	.display_page_select(display_page_select),
	.display_page_base(display_page_base),
	.drive_settled(drive_settled)
);

// ===== bench/lcdc_panel_model.sv
`timescale 1ns/1ps
module lcdc_panel_model #(
	parameter [59:0] PG0 = 60'h0,
	parameter [59:0] PG1 = 60'h0
) (
	input  logic [15:0] display_page_base,
	output logic [59:0] dot_mem_bits
);
	// Serves only the populated page pointed at
	assign dot_mem_bits = (display_page_base == 16'hF100) ? PG1 : PG0;
endmodule // lcdc_panel_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam [59:0] P0 = 60'hA5A5A5A5A5A5A5A;
	localparam [59:0] P1 = 60'h0F00FF000FFF0F0;
	localparam [15:0] FV = 16'h0462;
	logic        sys_clk = 1'h0, srst = 1'h1;
	logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid, drive_settled;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [59:0]  dot_mem_bits, segment_terminals_on;
	wire         bias_generator_power, drive_to_ground, duty_select_low;
	wire         duty_select_high, force_all_dots_on, force_all_dots_off;
	wire         display_page_select, expansion_driver_signal_enable;
	wire [4:0]   common_terminals_used;
	wire [15:0]  display_page_base;
	wire [3:0]   contrast_code;
	integer      mismatches = 0, tests_run = 0, k;
	logic [3:0]  v;
	logic [3:0]  strb = 4'hF;
	lcdc_ctrl_regs #(
		.SETTLE_CYCLES(20)
	) i_dut (
		.sys_clk(sys_clk),
		.srst(srst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.dot_mem_bits(dot_mem_bits),
		.bias_generator_power(bias_generator_power),
		.drive_to_ground(drive_to_ground),
		.duty_select_low(duty_select_low),
		.duty_select_high(duty_select_high),
		.common_terminals_used(common_terminals_used),
		.force_all_dots_on(force_all_dots_on),
		.force_all_dots_off(force_all_dots_off),
		.segment_terminals_on(segment_terminals_on),
		.display_page_select(display_page_select),
		.display_page_base(display_page_base),
		.contrast_code(contrast_code),
		.expansion_driver_signal_enable(expansion_driver_signal_enable),
		.drive_settled(drive_settled)
	);
	lcdc_panel_model #(
		.PG0(P0),
		.PG1(P1)
	) i_panel (
		.display_page_base(display_page_base),
		.dot_mem_bits(dot_mem_bits)
	);
	initial forever #10 sys_clk = ~sys_clk;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input [63:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input bit w, input [15:0] i, input [3:0] d,
		input [1:0] er);
		integer n;
		bit dn;
		dn = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_araddr <= {i, 2'h0};
		s_axi_wdata <= {28'h0, d};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (n = 0; n < 50 && !dn; n++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (w && s_axi_bvalid) begin
				chk("bresp", s_axi_bresp, er);
				s_axi_bready <= 1'h0;
				dn = 1;
			end
			if (!w && s_axi_rvalid) begin
				chk("rdata", s_axi_rdata, {28'h0, d});
				chk("rresp", s_axi_rresp, er);
				s_axi_rready <= 1'h0;
				dn = 1;
			end
		end
		if (!dn) begin
			chk("done", dn, 1'h1);
			stop_test();
		end
	endtask
	task automatic look;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		srst <= 1'h0;
		#1;
		chk("gnd", drive_to_ground, 1'h1);
		chk("coms", common_terminals_used, 5'h11);
		xfer(0, 16'hFF60, 4'h0, 2'h0);
		xfer(0, 16'hFF61, 4'h4, 2'h0);
		// Contrast extremes, then the room default
		for (k = 0; k < 3; k++) begin
			v = (k == 2) ? 4'h7 : {4{k[0]}};
			xfer(1, 16'hFF62, v, 2'h0);
			xfer(0, 16'hFF62, v, 2'h0);
			chk("con", contrast_code, v);
		end
		strb = 4'hE;
		xfer(1, 16'hFF62, 4'h3, 2'h0);
		strb = 4'hF;
		xfer(0, 16'hFF62, 4'h7, 2'h0);
		for (k = 0; k < 4; k++) begin
			v = FV[k*4 +: 4];
			xfer(1, 16'hFF61, v, 2'h0);
			look();
			chk("segs", segment_terminals_on, k < 2 ? {60{1'h1}} :
				k == 2 ? 60'h0 : P0);
			chk("off", force_all_dots_off, k == 2);
			chk("on", force_all_dots_on, k < 2);
		end
		xfer(1, 16'hFF61, 4'h9, 2'h0);
		xfer(0, 16'hFF61, 4'h9, 2'h0);
		chk("page", display_page_select, 1'h1);
		for (k = 0; k < 4; k++) begin
			v = {k[1:0], 2'h2};
			xfer(1, 16'hFF60, v, 2'h0);
			look();
			chk("coms", common_terminals_used, k > 1 ? 5'h08 :
				k == 1 ? 5'h10 : 5'h11);
			chk("base", display_page_base,
				k > 1 ? 16'hF100 : 16'hF000);
			chk("segs", segment_terminals_on, k > 1 ? P1 : P0);
			chk("duty", {duty_select_high, duty_select_low}, k[1:0]);
			xfer(0, 16'hFF60, v, 2'h0);
		end
		xfer(1, 16'hFF61, 4'h8, 2'h0);
		look();
		chk("base", display_page_base, 16'hF000);
		chk("exp", expansion_driver_signal_enable, 1'h1);
		xfer(1, 16'hFF60, 4'h1, 2'h0);
		for (k = 0; k < 60 && drive_settled !== 1'h1; k++)
			@(posedge sys_clk);
		chk("settled", drive_settled, 1'h1);
		chk("pwr", bias_generator_power, 1'h1);
		chk("gnd", drive_to_ground, 1'h0);
		xfer(0, 16'hFF63, 4'h1, 2'h0);
		xfer(1, 16'hFF63, 4'h0, 2'h0);
		xfer(0, 16'hFF63, 4'h1, 2'h0);
		xfer(1, 16'hFF60, 4'h0, 2'h0);
		look();
		chk("gnd", drive_to_ground, 1'h1);
		chk("pwr", bias_generator_power, 1'h0);
		chk("settled", drive_settled, 1'h0);
		xfer(1, 16'h0000, 4'hF, 2'h2);
		xfer(0, 16'h0000, 4'h0, 2'h2);
		stop_test();
	end
endmodule // tb_top
